// ===== rtl/i2c_master_pkg.sv
// Constants, register map and carrier types for the two-wire bus master.
// Assumes a single core clock and a word-addressed Avalon-MM register port.
package i2c_master_pkg;

  // Register indices; the word address on the bus equals the index.
  localparam logic [7:0] REG_TX_DATA = 8'h9A;
  localparam logic [7:0] REG_RX_DATA = 8'h9B;
  localparam logic [7:0] REG_MODE = 8'hE8;
  localparam logic [7:0] REG_TARGET = 8'hE9;
  localparam logic [7:0] REG_STATUS = 8'hEA;

  // Values after reset.
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] TARGET_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // Field positions of the mode register.
  localparam int MODE_ENABLE = 7;
  localparam int MODE_DIV_HI = 6;
  localparam int MODE_DIV_LO = 5;
  localparam int MODE_COUNT_HI = 4;

  // Field positions of the status register.
  localparam int STAT_BUSY = 7;
  localparam int STAT_NOACK = 6;
  localparam int STAT_RX = 5;
  localparam int STAT_TX = 4;
  localparam int STAT_FILL_HI = 3;
  localparam int STAT_FILL_LO = 2;
  localparam int STAT_ACC_ERR = 1;
  localparam int STAT_OVF_ERR = 0;
  localparam logic [7:0] STAT_W0C_MASK = 8'h73;
  localparam logic [7:0] STAT_IRQ_MASK = 8'h70;

  // Fill level codes of the active FIFO.
  localparam logic [1:0] FILL_EMPTY = 2'h0;
  localparam logic [1:0] FILL_HALF = 2'h2;
  localparam logic [1:0] FILL_FULL = 2'h3;

  // Depth of each FIFO and serial clock timing in core cycles.
  localparam int FIFO_DEPTH = 4;
  localparam int SCL_DIV_BASE = 16;
  localparam logic [5:0] QUARTER_BASE = 6'(SCL_DIV_BASE / 4);
  localparam logic [3:0] ACK_BIT = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_START = 4'h2,
    ST_BYTE = 4'h4,
    ST_STOP = 4'h8
  } bus_phase_e;

  // Open-drain drive of the two bus lines; an enable pulls the line low.
  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } pin_drive_s;

  // Levels seen on the two bus lines.
  typedef struct packed {
    logic scl;
    logic sda;
  } pin_sense_s;

endpackage

// ===== rtl/i2c_master_status_fifo.sv
// Two-wire bus master with 4-byte transmit and receive FIFOs and status flags.
// Assumes an Avalon-MM master on the core clock and pull-ups on both bus lines.
//
// What this block does
// - Busy flag bit 7 is set while the bus is in use; write transfers drain the TX FIFO.
// - Missing slave acknowledge sets bit 6, stops the transfer; writing zero clears it.
// - Bit 5 stays set while the RX FIFO holds data; writing zero clears it.
// - Bit 4 is set when the TX FIFO becomes empty; writing zero clears it.
// - Bits 3:2 show active FIFO level: 00 empty, 10 half, 11 full.
// - Bit 1 flags a data write and read colliding; writing zero clears it.
// - Bit 0 flags a TX write while the TX FIFO is full; zero clears.
// - Target address bit 0 selects direction: one reads, zero writes.
// - The master acknowledges each received byte but the last by itself during reads.
// - The final read byte gets a NACK once the programmed count arrives.
// - Rewriting the target address mid-transfer gives a repeated start, then the new transfer.
// - Receive and transmit FIFOs are four bytes deep; TX may be preloaded.
// - An emptied TX FIFO raises the transmit flag and the interrupt request.
// - A write transfer stops when no next byte waits in the TX FIFO.
// - A missing acknowledge ends the transfer; during a write it also flushes the TX FIFO.
// - Up to four received bytes wait; the receive flag stays set while any wait.
// - A read stops once the received count reaches the programmed count plus one.
// - With the enable bit set, a target address write starts a transfer.
// - Serial clock is core clock over 16 times two to the divider select.
// - The read length is the count field value plus one byte.
`timescale 1ns/1ps
`default_nettype none

module i2c_master_status_fifo #(
  parameter int DEPTH = i2c_master_pkg::FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire i2c_master_pkg::pin_sense_s pin_in,
  output i2c_master_pkg::pin_drive_s pin_out,
  output logic serial_irq
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;

  typedef struct packed {
    i2c_master_pkg::bus_phase_e fsm;
    logic [1:0] phase;
    logic [5:0] tick;
    logic [3:0] bitn;
    logic [7:0] shreg;
    logic is_rx;
    logic is_addr;
    logic nack_seen;
    logic dir;
    logic restart;
    logic [5:0] rx_bytes;
    logic [7:0] mode;
    logic [7:0] target;
    logic [7:0] stat;
    logic [DEPTH-1:0][7:0] tx_mem;
    logic [PW-1:0] tx_rd;
    logic [PW-1:0] tx_wr;
    logic [CW-1:0] tx_cnt;
    logic [DEPTH-1:0][7:0] rx_mem;
    logic [PW-1:0] rx_rd;
    logic [PW-1:0] rx_wr;
    logic [CW-1:0] rx_cnt;
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [31:0] readdata;
    logic waitrequest;
    i2c_master_pkg::pin_drive_s pins;
    logic irq;
  } engine_s;

  localparam engine_s RESET_ST = '{
    fsm: i2c_master_pkg::ST_IDLE,
    mode: i2c_master_pkg::MODE_RESET,
    target: i2c_master_pkg::TARGET_RESET,
    stat: i2c_master_pkg::STATUS_RESET,
    waitrequest: 1'b1,
    default: '0
  };

  engine_s st_reg;
  engine_s st_next;
  logic [5:0] quarter;
  logic stall;
  logic tick_now;
  logic last_rx;
  logic byte_done;
  logic bus_acc;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic [7:0] w0c;
  logic [1:0] fill;

  // Length of one quarter of a serial clock period for the divider select.
  function automatic logic [5:0] quarter_len(input logic [1:0] sel);
    quarter_len = i2c_master_pkg::QUARTER_BASE << sel;
  endfunction

  // Maps a FIFO count to the two-bit level code; 01 is never produced.
  function automatic logic [1:0] fill_code(input logic [CW-1:0] cnt);
    if (cnt == '0) begin
      fill_code = i2c_master_pkg::FILL_EMPTY;
    end else if (cnt == CW'(DEPTH)) begin
      fill_code = i2c_master_pkg::FILL_FULL;
    end else begin
      fill_code = i2c_master_pkg::FILL_HALF;
    end
  endfunction

  // Whole next state: synchronisers, bit engine, FIFOs, bus slave and flags.
  always_comb begin
    st_next = st_reg;
    flag_set = 8'h00;
    flag_clr = 8'h00;
    st_next.scl_sync = {st_reg.scl_sync[0], pin_in.scl};
    st_next.sda_sync = {st_reg.sda_sync[0], pin_in.sda};
    st_next.pins.scl_o = 1'b0;
    st_next.pins.sda_o = 1'b0;
    quarter = quarter_len(st_reg.mode[i2c_master_pkg::MODE_DIV_HI:i2c_master_pkg::MODE_DIV_LO]);
    last_rx = (st_reg.rx_bytes == {1'b0, st_reg.mode[i2c_master_pkg::MODE_COUNT_HI:0]});
    // Hold SCL low before a new received byte while the RX FIFO is full. A stretching slave
    // is waited for only at the end of the first high quarter, so sync delay stays out of the bit.
    stall = (st_reg.fsm == i2c_master_pkg::ST_BYTE && st_reg.is_rx && st_reg.bitn == 4'h0
             && st_reg.phase == 2'h0 && st_reg.rx_cnt == CW'(DEPTH))
            || (st_reg.phase == 2'h1 && !st_reg.scl_sync[1] && st_reg.tick == quarter - 6'h01);
    tick_now = st_reg.fsm != i2c_master_pkg::ST_IDLE && !stall && st_reg.tick == quarter - 6'h01;
    byte_done = tick_now && st_reg.phase == 2'h3 && st_reg.fsm == i2c_master_pkg::ST_BYTE
                && st_reg.bitn == i2c_master_pkg::ACK_BIT;

    // Quarter-period counter; four quarters make one bit of 16 << select cycles.
    if (st_reg.fsm == i2c_master_pkg::ST_IDLE || tick_now) begin
      st_next.tick = 6'h00;
    end else if (!stall) begin
      st_next.tick = st_reg.tick + 6'h01;
    end

    // Bit engine: release SCL, sample, pull SCL low, then step to the next bit.
    if (tick_now) begin
      st_next.phase = st_reg.phase + 2'h1;
      case (st_reg.phase)
        2'h0: begin
          st_next.pins.scl_oe = 1'b0;
        end
        2'h1: begin
          if (st_reg.fsm == i2c_master_pkg::ST_START) begin
            st_next.pins.sda_oe = 1'b1;
          end else if (st_reg.fsm == i2c_master_pkg::ST_STOP) begin
            st_next.pins.sda_oe = 1'b0;
          end else if (st_reg.bitn == i2c_master_pkg::ACK_BIT) begin
            if (!st_reg.is_rx) begin
              st_next.nack_seen = st_reg.sda_sync[1];
            end
          end else if (st_reg.is_rx) begin
            st_next.shreg = {st_reg.shreg[6:0], st_reg.sda_sync[1]};
          end
        end
        2'h2: begin
          // During stop SCL stays released so the bus ends idle.
          st_next.pins.scl_oe = st_reg.fsm != i2c_master_pkg::ST_STOP;
        end
        default: begin
          case (st_reg.fsm)
            i2c_master_pkg::ST_START: begin
              st_next.fsm = i2c_master_pkg::ST_BYTE;
              // The address byte was latched when this transfer was requested.
              st_next.dir = st_reg.shreg[0];
              st_next.is_addr = 1'b1;
              st_next.is_rx = 1'b0;
              st_next.bitn = 4'h0;
              st_next.rx_bytes = 6'h00;
              st_next.pins.sda_oe = !st_reg.shreg[7];
            end
            i2c_master_pkg::ST_BYTE: begin
              if (st_reg.bitn != i2c_master_pkg::ACK_BIT) begin
                st_next.bitn = st_reg.bitn + 4'h1;
                if (st_reg.is_rx) begin
                  // Ack for every byte but the last, which is left high as NACK.
                  st_next.pins.sda_oe = st_next.bitn == i2c_master_pkg::ACK_BIT && !last_rx;
                end else begin
                  st_next.shreg = {st_reg.shreg[6:0], 1'b0};
                  st_next.pins.sda_oe = st_next.bitn != i2c_master_pkg::ACK_BIT
                                        && !st_next.shreg[7];
                end
              end else begin
                st_next.bitn = 4'h0;
                st_next.pins.sda_oe = 1'b0;
                if (st_reg.is_rx) begin
                  st_next.rx_mem[st_reg.rx_wr] = st_reg.shreg;
                  st_next.rx_wr = st_reg.rx_wr + PW'(1);
                  st_next.rx_cnt = st_reg.rx_cnt + CW'(1);
                  st_next.rx_bytes = st_reg.rx_bytes + 6'h01;
                  if (last_rx) begin
                    st_next.fsm = i2c_master_pkg::ST_STOP;
                  end
                end else if (st_reg.nack_seen) begin
                  flag_set[i2c_master_pkg::STAT_NOACK] = 1'b1;
                  st_next.fsm = i2c_master_pkg::ST_STOP;
                  if (!st_reg.dir) begin
                    st_next.tx_rd = st_reg.tx_wr;
                    st_next.tx_cnt = '0;
                  end
                end else if (st_reg.is_addr && st_reg.dir) begin
                  st_next.is_addr = 1'b0;
                  st_next.is_rx = 1'b1;
                end else if (st_reg.tx_cnt != '0) begin
                  st_next.shreg = st_reg.tx_mem[st_reg.tx_rd];
                  st_next.tx_rd = st_reg.tx_rd + PW'(1);
                  st_next.tx_cnt = st_reg.tx_cnt - CW'(1);
                  st_next.is_addr = 1'b0;
                  st_next.pins.sda_oe = !st_next.shreg[7];
                end else begin
                  st_next.fsm = i2c_master_pkg::ST_STOP;
                end
                // A pending new address turns the stop into a repeated start.
                if (st_next.fsm == i2c_master_pkg::ST_STOP) begin
                  st_next.fsm = st_reg.restart ? i2c_master_pkg::ST_START
                                               : i2c_master_pkg::ST_STOP;
                  st_next.pins.sda_oe = !st_reg.restart;
                  st_next.restart = 1'b0;
                  st_next.shreg = st_reg.target;
                end
              end
            end
            default: begin
              st_next.fsm = st_reg.restart ? i2c_master_pkg::ST_START
                                           : i2c_master_pkg::ST_IDLE;
              st_next.restart = 1'b0;
              st_next.shreg = st_reg.target;
            end
          endcase
        end
      endcase
    end

    // Avalon slave: a request is taken while waitrequest is high and answered
    // one cycle later, so every access costs exactly two cycles.
    bus_acc = (read || write) && st_reg.waitrequest;
    st_next.waitrequest = !bus_acc;
    if (bus_acc && read) begin
      case (address)
        i2c_master_pkg::REG_MODE: st_next.readdata = {24'h000000, st_reg.mode};
        i2c_master_pkg::REG_TARGET: st_next.readdata = {24'h000000, st_reg.target};
        i2c_master_pkg::REG_STATUS: st_next.readdata = {24'h000000, st_reg.stat};
        i2c_master_pkg::REG_RX_DATA: begin
          // The single fixed-latency answer is what keeps the pop to one byte.
          st_next.readdata = {24'h000000, st_reg.rx_cnt != '0 ? st_reg.rx_mem[st_reg.rx_rd]
                                                              : 8'h00};
          if (st_reg.rx_cnt != '0) begin
            st_next.rx_rd = st_next.rx_rd + PW'(1);
            st_next.rx_cnt = st_next.rx_cnt - CW'(1);
          end
          if (st_reg.fsm != i2c_master_pkg::ST_IDLE && !st_reg.dir) begin
            flag_set[i2c_master_pkg::STAT_ACC_ERR] = 1'b1;
          end
        end
        default: st_next.readdata = 32'h00000000;
      endcase
    end else if (bus_acc && write) begin
      case (address)
        i2c_master_pkg::REG_MODE: st_next.mode = writedata[7:0];
        i2c_master_pkg::REG_TARGET: begin
          st_next.target = writedata[7:0];
          if (st_reg.mode[i2c_master_pkg::MODE_ENABLE]) begin
            if (st_reg.fsm == i2c_master_pkg::ST_IDLE) begin
              st_next.fsm = i2c_master_pkg::ST_START;
              st_next.phase = 2'h0;
              st_next.shreg = writedata[7:0];
            end else begin
              st_next.restart = 1'b1;
            end
          end
        end
        i2c_master_pkg::REG_STATUS: begin
          flag_clr = ~writedata[7:0] & i2c_master_pkg::STAT_W0C_MASK;
        end
        i2c_master_pkg::REG_TX_DATA: begin
          if (st_reg.fsm != i2c_master_pkg::ST_IDLE && st_reg.dir) begin
            flag_set[i2c_master_pkg::STAT_ACC_ERR] = 1'b1;
          end
          if (st_next.tx_cnt == CW'(DEPTH)) begin
            flag_set[i2c_master_pkg::STAT_OVF_ERR] = 1'b1;
          end else begin
            st_next.tx_mem[st_next.tx_wr] = writedata[7:0];
            st_next.tx_wr = st_next.tx_wr + PW'(1);
            st_next.tx_cnt = st_next.tx_cnt + CW'(1);
          end
        end
        default: begin
        end
      endcase
    end

    // Status: hardware set wins over a software clear in the same cycle.
    flag_set[i2c_master_pkg::STAT_RX] = st_next.rx_cnt != '0;
    flag_set[i2c_master_pkg::STAT_TX] = st_next.tx_cnt == '0 && st_reg.tx_cnt != '0;
    w0c = ((st_reg.stat & ~flag_clr) | flag_set) & i2c_master_pkg::STAT_W0C_MASK;
    fill = fill_code(st_next.target[0] ? st_next.rx_cnt : st_next.tx_cnt);
    st_next.stat = w0c;
    st_next.stat[i2c_master_pkg::STAT_BUSY] = st_next.fsm != i2c_master_pkg::ST_IDLE;
    st_next.stat[i2c_master_pkg::STAT_FILL_HI:i2c_master_pkg::STAT_FILL_LO] = fill;
    st_next.irq = |(st_next.stat & i2c_master_pkg::STAT_IRQ_MASK);
  end

  // One register holds the whole state; reset loads constants only.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_reg <= RESET_ST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign readdata = st_reg.readdata;
  assign waitrequest = st_reg.waitrequest;
  assign pin_out = st_reg.pins;
  assign serial_irq = st_reg.irq;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  busy_flag_a: assert property (
    st_reg.stat[i2c_master_pkg::STAT_BUSY] == (st_reg.fsm != i2c_master_pkg::ST_IDLE))
    else $error("Busy flag disagrees with bus state.");
  noack_stops_a: assert property (
    byte_done && !st_reg.is_rx && st_reg.nack_seen
    |=> st_reg.stat[i2c_master_pkg::STAT_NOACK] && st_reg.fsm != i2c_master_pkg::ST_BYTE)
    else $error("Missing acknowledge did not flag and stop.");
  rx_flag_held_a: assert property (
    st_reg.rx_cnt != '0 |-> st_reg.stat[i2c_master_pkg::STAT_RX])
    else $error("Receive flag low while receive FIFO holds data.");
  tx_drained_a: assert property (
    $past(st_reg.tx_cnt) != '0 && st_reg.tx_cnt == '0 |-> st_reg.stat[i2c_master_pkg::STAT_TX]
    && st_reg.irq)
    else $error("Emptied transmit FIFO did not flag.");
  fill_code_a: assert property (
    st_reg.stat[i2c_master_pkg::STAT_FILL_HI:i2c_master_pkg::STAT_FILL_LO] != 2'h1)
    else $error("Reserved fill level code shown.");
  tx_overflow_a: assert property (
    bus_acc && write && address == i2c_master_pkg::REG_TX_DATA && st_reg.tx_cnt == CW'(DEPTH)
    && st_reg.fsm == i2c_master_pkg::ST_IDLE
    |=> st_reg.stat[i2c_master_pkg::STAT_OVF_ERR] && st_reg.tx_cnt == CW'(DEPTH))
    else $error("Write to full transmit FIFO not flagged.");
  ack_drive_a: assert property (
    st_reg.fsm == i2c_master_pkg::ST_BYTE && st_reg.is_rx && st_reg.bitn == i2c_master_pkg::ACK_BIT
    && st_reg.phase != 2'h0 |-> st_reg.pins.sda_oe == !last_rx)
    else $error("Wrong acknowledge level on received byte.");
  read_stop_a: assert property (
    byte_done && st_reg.is_rx && last_rx |=> st_reg.fsm != i2c_master_pkg::ST_BYTE)
    else $error("Read did not end at the programmed count.");
  start_on_write_a: assert property (
    bus_acc && write && address == i2c_master_pkg::REG_TARGET
    && st_reg.mode[i2c_master_pkg::MODE_ENABLE] && st_reg.fsm == i2c_master_pkg::ST_IDLE
    |=> st_reg.fsm == i2c_master_pkg::ST_START && !st_reg.waitrequest)
    else $error("Address write did not start a transfer.");
  quarter_len_a: assert property (
    st_reg.tick < quarter)
    else $error("Quarter counter passed its divider limit.");

endmodule

`default_nettype wire

// ===== verif/i2c_slave_model.sv
// Behavioural slave on the two-wire bus: acknowledges, records written bytes, sends bytes.
// Assumes resolved open-drain levels on its inputs; it only ever pulls the data line low.
`timescale 1ns/1ps
`default_nettype none

module i2c_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_en,
  output logic sda_pull
);
  logic [7:0] shreg = 8'h00;
  logic [7:0] txsh = 8'h00;
  logic [7:0] rd_val = 8'h5A;
  logic rd = 1'b0;
  logic first = 1'b0;
  logic send = 1'b0;
  int bitn = 0;
  int n_sent = 0;
  int n_start = 0;
  int n_stop = 0;
  logic [7:0] got[$];

  initial sda_pull = 1'b0;

  // Start condition; the clock falls once before the first bit, hence the count from -1.
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      n_start++;
      bitn = -1;
      first = 1'b1;
    end
  end

  // Stop condition releases the line whatever phase the slave was in.
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      n_stop++;
      sda_pull = 1'b0;
    end
  end

  // Bits are sampled while the clock is high; bit 8 carries the acknowledge.
  always @(posedge scl) begin
    if (bitn >= 0 && bitn < 8) begin
      shreg = {shreg[6:0], sda};
    end else if (bitn == 8) begin
      send = rd && !sda;
    end
  end

  // The line only changes while the clock is low, as a real slave must.
  always @(negedge scl) begin
    bitn = bitn + 1;
    if (bitn == 8) begin
      if (first) begin
        rd = shreg[0];
      end
      if (!first && !rd) begin
        got.push_back(shreg);
      end
      sda_pull = (first || !rd) && ack_en;
      first = 1'b0;
    end else if (bitn == 9) begin
      bitn = 0;
      txsh = rd_val;
      sda_pull = send && !txsh[7];
      if (send) begin
        rd_val = rd_val + 8'h01;
        n_sent++;
      end
    end else if (bitn > 0 && rd && !first && send) begin
      sda_pull = !txsh[7 - bitn];
    end
  end
endmodule
`default_nettype wire

// ===== verif/tb_i2c_master_status_fifo.sv
// Self-checking bench for the bus master: Avalon-MM register tasks and transfer scenarios.
// Assumes the slave model on the bus lines; both lines have pull-ups resolved here.
`timescale 1ns/1ps
`default_nettype none

module tb_i2c_master_status_fifo;
  localparam logic [7:0] ST = i2c_master_pkg::REG_STATUS;
  localparam logic [7:0] TX = i2c_master_pkg::REG_TX_DATA;
  localparam logic [7:0] RX = i2c_master_pkg::REG_RX_DATA;
  localparam logic [7:0] MD = i2c_master_pkg::REG_MODE;
  localparam logic [7:0] TG = i2c_master_pkg::REG_TARGET;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [31:0] readdata;
  logic waitrequest;
  logic serial_irq;
  logic sda_pull;
  logic ack_en = 1'b1;
  logic [7:0] q;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  int n0;
  int s0;
  time t0;
  i2c_master_pkg::pin_drive_s pin_out;
  wire logic scl_w = !pin_out.scl_oe;
  wire logic sda_w = !(pin_out.sda_oe || sda_pull);
  wire i2c_master_pkg::pin_sense_s pin_in = {scl_w, sda_w};

  i2c_master_status_fifo dut (.clock(clock), .resetn(resetn), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .pin_in(pin_in), .pin_out(pin_out), .serial_irq(serial_irq));
  i2c_slave_model sl (.scl(scl_w), .sda(sda_w), .ack_en(ack_en), .sda_pull(sda_pull));

  always #10 clock = !clock;

  // A hang would otherwise stall the run; the whole sequence needs well under this many cycles.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One access; starting a cycle late keeps the release and the next request apart.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= {24'h000000, d};
    do @(posedge clock); while (waitrequest !== 1'b0);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic expect_reg(input string what, input logic [7:0] a, input logic [7:0] m,
                            input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check(what, q & m, e);
  endtask

  task automatic wait_idle();
    do bus(1'b0, ST, 8'h00); while (q[i2c_master_pkg::STAT_BUSY] !== 1'b0);
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    // Reset values and an unmapped place.
    expect_reg("status reset", ST, 8'hFF, i2c_master_pkg::STATUS_RESET);
    expect_reg("mode reset", MD, 8'hFF, i2c_master_pkg::MODE_RESET);
    expect_reg("target reset", TG, 8'hFF, i2c_master_pkg::TARGET_RESET);
    expect_reg("unmapped", 8'h10, 8'hFF, 8'h00);
    // Write of four preloaded bytes, with overflow and access collision on the way.
    bus(1'b1, MD, 8'h80);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, TX, 8'h11 + 8'(i));
    end
    expect_reg("fill full", ST, 8'hFF, 8'h0C);
    bus(1'b1, TX, 8'h15);
    expect_reg("overflow", ST, 8'hFF, 8'h0D);
    bus(1'b1, ST, 8'hFF);
    expect_reg("write one keeps", ST, 8'hFF, 8'h0D);
    bus(1'b1, ST, 8'hFE);
    expect_reg("overflow clear", ST, 8'hFF, 8'h0C);
    bus(1'b1, TG, 8'hA0);
    expect_reg("busy", ST, 8'h80, 8'h80);
    bus(1'b0, RX, 8'h00);
    expect_reg("access error", ST, 8'h02, 8'h02);
    bus(1'b1, ST, 8'hFD);
    expect_reg("access clear", ST, 8'h02, 8'h00);
    wait_idle();
    check("bytes sent", 8'(sl.got.size()), 8'h04);
    for (int i = 0; i < 4; i++) begin
      check("byte on wire", sl.got[i], 8'h11 + 8'(i));
    end
    expect_reg("tx drained", ST, 8'hFF, 8'h10);
    check("irq", {7'h00, serial_irq}, 8'h01);
    bus(1'b1, ST, 8'h00);
    expect_reg("tx clear", ST, 8'hFF, 8'h00);
    // Read of count plus one bytes fills the receive FIFO exactly.
    bus(1'b1, MD, 8'h83);
    bus(1'b1, TG, 8'hA1);
    wait_idle();
    expect_reg("rx full", ST, 8'hFF, 8'h2C);
    check("bytes read", 8'(sl.n_sent), 8'h04);
    check("last byte nacked", {7'h00, sl.send}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      expect_reg("rx byte", RX, 8'hFF, 8'h5A + 8'(i));
    end
    expect_reg("rx flag holds", ST, 8'hFF, 8'h20);
    bus(1'b1, ST, 8'h00);
    expect_reg("rx clear", ST, 8'hFF, 8'h00);
    // Missing acknowledge at the slower divider setting.
    ack_en = 1'b0;
    bus(1'b1, MD, 8'hA0);
    bus(1'b1, TX, 8'h21);
    bus(1'b1, TX, 8'h22);
    bus(1'b1, TG, 8'hA0);
    @(posedge scl_w);
    t0 = $time;
    @(posedge scl_w);
    check("scl period", 8'(($time - t0) / 20), 8'h20);
    wait_idle();
    expect_reg("noack", ST, 8'hC0, 8'h40);
    expect_reg("flushed", ST, 8'h0C, 8'h00);
    check("no data after nack", 8'(sl.got.size()), 8'h04);
    bus(1'b1, ST, 8'h00);
    expect_reg("noack clear", ST, 8'h40, 8'h00);
    // Rewriting the target mid-transfer chains a read behind the write.
    ack_en = 1'b1;
    bus(1'b1, MD, 8'h80);
    bus(1'b1, TX, 8'h33);
    n0 = sl.n_start;
    s0 = sl.n_stop;
    bus(1'b1, TG, 8'hA0);
    bus(1'b1, TG, 8'hA1);
    wait_idle();
    check("starts", 8'(sl.n_start - n0), 8'h02);
    check("stops", 8'(sl.n_stop - s0), 8'h01);
    check("written byte", sl.got[4], 8'h33);
    expect_reg("read after restart", RX, 8'hFF, 8'h5E);
    conclude();
  end
endmodule
`default_nettype wire
